// [dv/mcuic_checker.sv]
`timescale 1ns/1ps
module mcuic_checker
(
  input logic       clk_i,
  input logic       rst_i,
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  input logic       wb_we_i,
  input logic       wb_ack_o,
  input logic [7:0] timer0_count_i,
  input logic [7:0] timer0_reference_i,
  input logic       basic_timer_interval_i,
  input logic       serial_done_i,
  input logic [6:0] cpu_service_i,
  input logic [6:0] irq_req_o,
  input logic [6:0] irq_high_o,
  input logic       irq_o
);
  // A software write may legally set or clear any flag, so it is excused.
  wire wr = wb_ack_o & wb_we_i;
  wire match = timer0_count_i == timer0_reference_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  property p_rst_clear;
    $fell(rst_i) |-> irq_req_o == 7'h00 && !irq_o && !wb_ack_o;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("not clear");
  property p_serial_cause;
    $rose(irq_req_o[3]) |-> $past(serial_done_i) || $past(wr);
  endproperty
  a_serial_cause: assert property (p_serial_cause) else $error("serial");
  property p_basic_cause;
    $rose(irq_req_o[0]) |-> $past(basic_timer_interval_i) || $past(wr);
  endproperty
  a_basic_cause: assert property (p_basic_cause) else $error("basic");
  property p_timer0_cause;
    $rose(irq_req_o[4])
      |-> $past(match) || $past(wr);
  endproperty
  a_timer0_cause: assert property (p_timer0_cause) else $error("timer0");
  property p_serial_clear;
    cpu_service_i[3] && irq_req_o[3] && !serial_done_i && !wr
      |=> !irq_req_o[3];
  endproperty
  a_serial_clear: assert property (p_serial_clear) else $error("svc");
  property p_watch_hold;
    irq_req_o[5] && !wr |=> irq_req_o[5];
  endproperty
  a_watch_hold: assert property (p_watch_hold) else $error("watch");
  property p_key_hold;
    irq_req_o[6] && !wr |=> irq_req_o[6];
  endproperty
  a_key_hold: assert property (p_key_hold) else $error("key");
  property p_high_sub;
    (irq_high_o & ~irq_req_o) == 7'h00 && $onehot0(irq_high_o);
  endproperty
  a_high_sub: assert property (p_high_sub) else $error("priority");
endmodule
bind mcuic_top mcuic_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .timer0_count_i, .timer0_reference_i,
  .basic_timer_interval_i, .serial_done_i, .cpu_service_i, .irq_req_o,
  .irq_high_o, .irq_o);

// [dv/mcuic_cpu_model.sv]
`timescale 1ns/1ps
`include "mcuic_defines.vh"
module mcuic_cpu_model
(
  input  logic       clk_i,
  input  logic       rst_i,
  input  logic       hold_i,
  input  logic [6:0] req_i,
  output logic [6:0] service_o
);
  // Holding stands for a slow core; quasi sources are never serviced.
  always @(posedge clk_i)
  begin
    if (rst_i || hold_i)
      service_o <= 7'h00;
    else
      service_o <= req_i & ~service_o & `MCUIC_AUTO_CLEAR;
  end
endmodule

// [dv/mcuic_top_test.sv]
`timescale 1ns/1ps
`include "mcuic_defines.vh"
module mcuic_top_test;
  typedef struct packed
  {
    logic [3:0]  e;
    logic [13:0] idx;
    logic [6:0]  on;
    logic [6:0]  left;
  } mcuic_row_t;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic        ext_pin0_i, ext_pin1_i, key_input_a_i, key_input_b_i, hold;
  logic        key_input_c_i, tick;
  logic [15:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [6:0]  cpu_service_i, irq_req_o, irq_high_o;
  logic [3:0]  ev;
  int          fail_count, checked;
  mcuic_row_t  rows [4] = '{'{4'h1, `MCUIC_IDX_BASIC, 7'h01, 7'h00},
    '{4'h2, `MCUIC_IDX_SERIAL, 7'h08, 7'h00},
    '{4'h8, `MCUIC_IDX_TIMER0, 7'h10, 7'h00},
    '{4'h4, `MCUIC_IDX_WATCH, 7'h20, 7'h20}};
  mcuic_top dut
  (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .timer0_count_i(ev[3] ? 8'h5a : 8'h00), .timer0_reference_i(8'h5a),
    .watch_interval_i(ev[2]), .basic_timer_interval_i(ev[0]),
    .serial_done_i(ev[1]), .ext_pin0_i, .ext_pin1_i, .key_input_a_i,
    .key_input_b_i, .key_input_c_i, .cpu_cpu_clk_tick_i(tick),
    .cpu_service_i, .irq_req_o, .irq_high_o, .irq_o
  );
  mcuic_cpu_model cpu
  (
    .clk_i, .rst_i, .hold_i(hold), .req_i(irq_req_o),
    .service_o(cpu_service_i)
  );
  task automatic results;
    $display("Mismatches %0d, comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [13:0] idx,
                     input logic [6:0] d);
    int n;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_dat_i} <= {idx, 2'b00, 25'h0, d};
    for (n = 0; n < 50 && wb_ack_o !== 1'b1; n++)
      @(posedge clk_i);
    if (n == 50)
    begin
      fail_count++;
      results;
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk_i);
  endtask
  task automatic pulse(input logic [3:0] e);
    ev <= e;
    @(posedge clk_i);
    ev <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, hold, key_input_a_i, key_input_b_i, key_input_c_i, tick} = 6'h3f;
    {wb_cyc_i, wb_stb_i, wb_we_i, ext_pin0_i, ext_pin1_i} = 5'h00;
    {wb_adr_i, wb_dat_i, ev} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(irq_req_o, 7'h00);
    bus(1'b0, `MCUIC_IDX_PRIORITY, 7'h00);
    chk(rd, 32'h0);
    bus(1'b0, `MCUIC_IDX_EXT, 7'h00);
    chk(rd, 32'h0);
    bus(1'b0, 14'h0100, 7'h00);
    chk(rd, 32'h0);
    bus(1'b1, `MCUIC_IDX_PRIORITY, 7'h08);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].idx, 7'h02);
      pulse(rows[i].e);
      chk(irq_req_o, rows[i].on);
      hold <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk(irq_req_o, rows[i].left);
      hold <= 1'b1;
      bus(1'b1, rows[i].idx, 7'h00);
      pulse(rows[i].e);
      chk(irq_req_o, 7'h00);
    end
    bus(1'b1, `MCUIC_IDX_PRIORITY, 7'h00);
    bus(1'b1, `MCUIC_IDX_SERIAL, 7'h02);
    pulse(4'h2);
    chk(irq_req_o, 7'h00);
    for (int c = 0; c < 6; c++)
    begin
      bus(1'b1, `MCUIC_IDX_PRIORITY, 7'h08 | c[6:0]);
      chk(irq_req_o, 7'h08);
      chk(irq_high_o, (c == 4) ? 7'h08 : 7'h00);
    end
    bus(1'b1, `MCUIC_IDX_EVT_MASK, 7'h08);
    chk(irq_o, 1'b1);
    bus(1'b1, `MCUIC_IDX_EVT_MASK, 7'h00);
    chk(irq_o, 1'b0);
    bus(1'b1, `MCUIC_IDX_EVT_MASK, 7'h08);
    bus(1'b1, `MCUIC_IDX_EVT_STATUS, 7'h08);
    chk(irq_o, 1'b0);
    bus(1'b0, `MCUIC_IDX_EVT_STATUS, 7'h00);
    chk(rd, 32'h31);
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, `MCUIC_IDX_EXT0_MODE, m[6:0]);
      bus(1'b1, `MCUIC_IDX_EXT1_MODE, {6'h0, m[0]});
      bus(1'b1, `MCUIC_IDX_EXT, 7'h0a);
      {ext_pin0_i, ext_pin1_i} <= 2'b11;
      repeat (4) @(posedge clk_i);
      chk(irq_req_o[2:1], {!m[0], m == 0 || m == 2});
      bus(1'b1, `MCUIC_IDX_EXT, 7'h0a);
      {ext_pin0_i, ext_pin1_i} <= 2'b00;
      repeat (4) @(posedge clk_i);
      chk(irq_req_o[2:1], {m[0], m == 1 || m == 2});
    end
    tick <= 1'b0;
    bus(1'b1, `MCUIC_IDX_EXT0_MODE, 7'h08);
    bus(1'b1, `MCUIC_IDX_EXT, 7'h02);
    ext_pin0_i <= 1'b1;
    repeat (66) @(posedge clk_i);
    chk(irq_req_o[1], 1'b1);
    bus(1'b1, `MCUIC_IDX_EXT0_MODE, 7'h01);
    bus(1'b1, `MCUIC_IDX_EXT, 7'h02);
    ext_pin0_i <= 1'b0;
    repeat (66) @(posedge clk_i);
    chk(irq_req_o[1], 1'b0);
    tick <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(irq_req_o[1], 1'b1);
    bus(1'b1, `MCUIC_IDX_KEY_MODE, 7'h02);
    bus(1'b1, `MCUIC_IDX_KEY, 7'h02);
    key_input_a_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(irq_req_o[6], 1'b0);
    key_input_b_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(irq_req_o[6], 1'b1);
    hold <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(irq_req_o, 7'h40);
    bus(1'b1, `MCUIC_IDX_KEY_MODE, 7'h04);
    bus(1'b1, `MCUIC_IDX_KEY, 7'h02);
    chk(irq_req_o[6], 1'b0);
    key_input_c_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(irq_req_o, 7'h40);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(irq_req_o, 7'h00);
    bus(1'b0, `MCUIC_IDX_KEY, 7'h00);
    chk(rd, 32'h0);
    results;
  end
endmodule

// [logic/mcuic_defines.vh]
`ifndef MCUIC_DEFINES_VH
`define MCUIC_DEFINES_VH

// Register indices; the byte address is four times the index.
`define MCUIC_IDX_PRIORITY   14'h0fb2
`define MCUIC_IDX_EXT0_MODE  14'h0fb4
`define MCUIC_IDX_EXT1_MODE  14'h0fb5
`define MCUIC_IDX_KEY_MODE   14'h0fb6
`define MCUIC_IDX_BASIC      14'h0fb8
`define MCUIC_IDX_WATCH      14'h0fba
`define MCUIC_IDX_TIMER0     14'h0fbc
`define MCUIC_IDX_SERIAL     14'h0fbd
`define MCUIC_IDX_EXT        14'h0fbe
`define MCUIC_IDX_KEY        14'h0fbf
`define MCUIC_IDX_EVT_STATUS 14'h0f00
`define MCUIC_IDX_EVT_MASK   14'h0f01

// Source numbering used by every 7-bit source vector in the block.
`define MCUIC_SRC_BASIC  0
`define MCUIC_SRC_EXT0   1
`define MCUIC_SRC_EXT1   2
`define MCUIC_SRC_SERIAL 3
`define MCUIC_SRC_TIMER0 4
`define MCUIC_SRC_WATCH  5
`define MCUIC_SRC_KEY    6
`define MCUIC_NSRC       7

// Sources whose flag hardware clears on service; the rest are quasi.
`define MCUIC_AUTO_CLEAR 7'h1f

// Field positions.
`define MCUIC_MASTER_EN_BIT 3
`define MCUIC_EXT0_SCLK     3
`define MCUIC_FLAG_BIT      0
`define MCUIC_EN_BIT        1
`define MCUIC_EXT1_FLAG     2
`define MCUIC_EXT1_EN       3

// Edge mode codes for external pin 0.
`define MCUIC_EDGE_RISE 2'h0
`define MCUIC_EDGE_FALL 2'h1
`define MCUIC_EDGE_BOTH 2'h2
`define MCUIC_EDGE_NONE 2'h3

// Reset values.
`define MCUIC_RST_MODE 4'h0
`define MCUIC_RST_VEC  7'h00

// Slow sampling divider for external pin 0.
`define MCUIC_SLOW_DIV     64
`define MCUIC_SLOW_DIV_MAX 6'h3f

`endif

// [logic/mcuic_edge.v]
`timescale 1ns/1ps
module mcuic_edge
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire sample_i,
  input  wire pin_i,
  output reg  rise_o,
  output reg  fall_o
);

  reg level;
  reg primed;

  // The first sample only primes the detector, so a pin that is already
  // high when reset releases does not report a false edge.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level  <= 1'b0;
      primed <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else
    begin
      rise_o <= sample_i & primed & pin_i & ~level;
      fall_o <= sample_i & primed & ~pin_i & level;
      if (sample_i)
      begin
        level  <= pin_i;
        primed <= 1'b1;
      end
    end
  end

endmodule

// [logic/mcuic_top.v]
// Function
// - Timer0 match request reaches the CPU only while its enable is set.
// - Timer0 match flag sets on count equal reference; service clears it.
// - Watch request reaches the CPU only while its enable is set.
// - Watch flag sets each time the watch timer reaches its interval.
// - Watch flag is never cleared by hardware, only by software.
// - Pin 0 mode bit 3 picks CPU clock or system clock over 64 sampling.
// - Pin 0 mode bits 1..0: rise, fall, both, or never set the flag.
// - Pin 1 mode bit 0 picks rising or falling edge detection.
// - Key mode bits 2..0 enable falling-edge detection per key input.
// - Master enable low inhibits irq_req_o and irq_high_o, not irq_o; high lets them through.
// - Priority bits 2..0 select one prioritised source or none.
// - Pin flags set on the selected edge and clear on service.
// - Key flag sets on an enabled falling edge; only software clears it.
// - Serial flag sets on transfer done and clears on service.
// - Basic timer flag sets on its interval signal, clears on service.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "mcuic_defines.vh"
module mcuic_top
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  timer0_count_i,
  input  wire [7:0]  timer0_reference_i,
  input  wire        watch_interval_i,
  input  wire        basic_timer_interval_i,
  input  wire        serial_done_i,
  input  wire        ext_pin0_i,
  input  wire        ext_pin1_i,
  input  wire        key_input_a_i,
  input  wire        key_input_b_i,
  input  wire        key_input_c_i,
  input  wire        cpu_cpu_clk_tick_i,
  input  wire [6:0]  cpu_service_i,
  output wire [6:0]  irq_req_o,
  output wire [6:0]  irq_high_o,
  output wire        irq_o
);

  reg  [3:0]  priority_reg;
  reg  [3:0]  ext0_mode_reg;
  reg  [3:0]  ext1_mode_reg;
  reg  [3:0]  key_mode_reg;
  reg  [6:0]  flag;
  reg  [6:0]  enable;
  reg  [6:0]  evt_status;
  reg  [6:0]  evt_mask;
  reg  [5:0]  slow_cnt;
  reg         match_d;
  reg  [31:0] next_rdata;

  wire [13:0] idx = wb_adr_i[15:2];
  wire        req = wb_cyc_i & wb_stb_i;
  wire        wr_stb = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [3:0]  wd = wb_dat_i[3:0];

  function hit;
    input [13:0] a;
    input [13:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  // Sample enables: the CPU clock tick or a divide-by-64 strobe.
  wire slow_tick = (slow_cnt == `MCUIC_SLOW_DIV_MAX);

  always @(posedge clk_i)
  begin
    if (rst_i)
      slow_cnt <= 6'h00;
    else
      slow_cnt <= slow_cnt + 6'h01;
  end

  wire ext0_sample = ext0_mode_reg[`MCUIC_EXT0_SCLK] ? slow_tick
                                                     : cpu_cpu_clk_tick_i;

  wire [4:0] pins = {key_input_c_i, key_input_b_i, key_input_a_i,
                     ext_pin1_i, ext_pin0_i};
  wire [4:0] smp  = {{4{cpu_cpu_clk_tick_i}}, ext0_sample};
  wire [4:0] rise;
  wire [4:0] fall;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : edges
      mcuic_edge u_edge
      (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (smp[g]),
        .pin_i    (pins[g]),
        .rise_o   (rise[g]),
        .fall_o   (fall[g])
      );
    end
  endgenerate

  reg ext0_set;

  always @*
  begin
    case (ext0_mode_reg[1:0])
      `MCUIC_EDGE_RISE: ext0_set = rise[0];
      `MCUIC_EDGE_FALL: ext0_set = fall[0];
      `MCUIC_EDGE_BOTH: ext0_set = rise[0] | fall[0];
      default:          ext0_set = 1'b0;
    endcase
  end

  wire ext1_set = ext1_mode_reg[0] ? fall[1] : rise[1];
  wire key_set  = |(fall[4:2] & key_mode_reg[2:0]);

  // Only the first cycle of a match sets the flag, so a serviced flag does
  // not come straight back while the counter rests on the reference.
  wire match = (timer0_count_i == timer0_reference_i);

  always @(posedge clk_i)
  begin
    if (rst_i)
      match_d <= 1'b0;
    else
      match_d <= match;
  end

  wire [6:0] set_evt;
  assign set_evt[`MCUIC_SRC_BASIC]  = basic_timer_interval_i;
  assign set_evt[`MCUIC_SRC_EXT0]   = ext0_set;
  assign set_evt[`MCUIC_SRC_EXT1]   = ext1_set;
  assign set_evt[`MCUIC_SRC_SERIAL] = serial_done_i;
  assign set_evt[`MCUIC_SRC_TIMER0] = match & ~match_d;
  assign set_evt[`MCUIC_SRC_WATCH]  = watch_interval_i;
  assign set_evt[`MCUIC_SRC_KEY]    = key_set;

  // Per-source register write strobes and the data bits they carry.
  wire [6:0] wr_src;
  wire [6:0] wflag;
  wire [6:0] wen;
  wire       ext_hit = hit(idx, `MCUIC_IDX_EXT);

  assign wr_src = {hit(idx, `MCUIC_IDX_KEY), hit(idx, `MCUIC_IDX_WATCH),
                   hit(idx, `MCUIC_IDX_TIMER0), hit(idx, `MCUIC_IDX_SERIAL),
                   ext_hit, ext_hit, hit(idx, `MCUIC_IDX_BASIC)}
                  & {7{wr_stb}};
  assign wflag  = {wd[`MCUIC_FLAG_BIT], wd[`MCUIC_FLAG_BIT],
                   wd[`MCUIC_FLAG_BIT], wd[`MCUIC_FLAG_BIT],
                   wd[`MCUIC_EXT1_FLAG], wd[`MCUIC_FLAG_BIT],
                   wd[`MCUIC_FLAG_BIT]};
  assign wen    = {wd[`MCUIC_EN_BIT], wd[`MCUIC_EN_BIT], wd[`MCUIC_EN_BIT],
                   wd[`MCUIC_EN_BIT], wd[`MCUIC_EXT1_EN], wd[`MCUIC_EN_BIT],
                   wd[`MCUIC_EN_BIT]};

  wire [6:0] auto_clr = cpu_service_i & `MCUIC_AUTO_CLEAR;

  // A hardware set in the same cycle as any clear always wins.
  generate
    for (g = 0; g < `MCUIC_NSRC; g = g + 1)
    begin : flags
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          flag[g]   <= 1'b0;
          enable[g] <= 1'b0;
        end
        else
        begin
          if (set_evt[g])
            flag[g] <= 1'b1;
          else if (wr_src[g])
            flag[g] <= wflag[g];
          else if (auto_clr[g])
            flag[g] <= 1'b0;
          if (wr_src[g])
            enable[g] <= wen[g];
        end
      end
    end
  endgenerate

  wire master_irq_enable = priority_reg[`MCUIC_MASTER_EN_BIT];

  assign irq_req_o = flag & enable
                     & {7{master_irq_enable}};

  reg [6:0] prio_sel;

  always @*
  begin
    case (priority_reg[2:0])
      3'h1:    prio_sel = 7'h01 << `MCUIC_SRC_BASIC;
      3'h2:    prio_sel = 7'h01 << `MCUIC_SRC_EXT0;
      3'h3:    prio_sel = 7'h01 << `MCUIC_SRC_EXT1;
      3'h4:    prio_sel = 7'h01 << `MCUIC_SRC_SERIAL;
      3'h5:    prio_sel = 7'h01 << `MCUIC_SRC_TIMER0;
      default: prio_sel = 7'h00;
    endcase
  end

  assign irq_high_o = irq_req_o & prio_sel;

  // Mode and control registers, cleared at reset.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      priority_reg  <= `MCUIC_RST_MODE;
      ext0_mode_reg <= `MCUIC_RST_MODE;
      ext1_mode_reg <= `MCUIC_RST_MODE;
      key_mode_reg  <= `MCUIC_RST_MODE;
      evt_mask      <= `MCUIC_RST_VEC;
    end
    else if (wr_stb)
    begin
      if (hit(idx, `MCUIC_IDX_PRIORITY))
        priority_reg <= wd;
      if (hit(idx, `MCUIC_IDX_EXT0_MODE))
        ext0_mode_reg <= {wd[3], 1'b0, wd[1:0]};
      if (hit(idx, `MCUIC_IDX_EXT1_MODE))
        ext1_mode_reg <= {3'h0, wd[0]};
      if (hit(idx, `MCUIC_IDX_KEY_MODE))
        key_mode_reg <= {1'b0, wd[2:0]};
      if (hit(idx, `MCUIC_IDX_EVT_MASK))
        evt_mask <= wb_dat_i[6:0];
    end
  end

  // Event status: set wins over a write-one clear in the same cycle.
  wire [6:0] st_clr = hit(idx, `MCUIC_IDX_EVT_STATUS) & wr_stb
                      ? wb_dat_i[6:0] : 7'h00;

  always @(posedge clk_i)
  begin
    if (rst_i)
      evt_status <= `MCUIC_RST_VEC;
    else
      evt_status <= set_evt | (evt_status & ~st_clr);
  end

  assign irq_o = |(evt_status & evt_mask);

  // Write-only registers read back as zero.
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (idx)
      `MCUIC_IDX_BASIC:      next_rdata[1:0] = {enable[0], flag[0]};
      `MCUIC_IDX_WATCH:      next_rdata[1:0] = {enable[5], flag[5]};
      `MCUIC_IDX_TIMER0:     next_rdata[1:0] = {enable[4], flag[4]};
      `MCUIC_IDX_SERIAL:     next_rdata[1:0] = {enable[3], flag[3]};
      `MCUIC_IDX_EXT:        next_rdata[3:0] = {enable[2], flag[2],
                                                enable[1], flag[1]};
      `MCUIC_IDX_KEY:        next_rdata[1:0] = {enable[6], flag[6]};
      `MCUIC_IDX_EVT_STATUS: next_rdata[6:0] = evt_status;
      `MCUIC_IDX_EVT_MASK:   next_rdata[6:0] = evt_mask;
      default:               next_rdata = 32'h0000_0000;
    endcase
  end

  // One wait state: ack comes one cycle after the request, for any address.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o)
        wb_dat_o <= next_rdata;
    end
  end

endmodule
